//--- logic/meas_pkg.sv
// shared constants and types for the battery measurement register bank
package meas_pkg;
  localparam logic [7:0]  ADDR_BATTERY_VOLTAGE         = 8'h09;
  localparam logic [7:0]  ADDR_BATTERY_CURRENT         = 8'h0a;
  localparam logic [7:0]  ADDR_BATTERY_CURRENT_AVERAGE = 8'h0b;
  localparam logic [7:0]  ADDR_BATTERY_VOLTAGE_AVERAGE = 8'h19;
  localparam logic [7:0]  ADDR_VOLTAGE_EXTREMES        = 8'h1b;
  localparam logic [15:0] EXTREMES_RESET               = 16'h00ff;
  localparam logic [7:0]  EXTREME_MAX_RESET            = 8'h00;
  localparam logic [7:0]  EXTREME_MIN_RESET            = 8'hff;
  localparam int          EXTREME_MAX_LSB              = 8;
  localparam int          EXTREME_MIN_LSB              = 0;
  // voltage lsb 78.125uV; 20mV byte lsb = 256 counts, so take bits [15:8]
  localparam int          VOLT_TO_BYTE_SHIFT           = 8;
  localparam int          AVG_SHIFT                    = 4;
  localparam logic [15:0] CURRENT_MAX_CODE             = 16'h7fff;
  localparam logic [15:0] CURRENT_MIN_CODE             = 16'h8000;
  localparam int          CURRENT_RAW_W                = 20;
  localparam int          NUM_REGS                     = 5;

  typedef struct packed {
    logic        wrEn;
    logic        rdEn;
    logic [7:0]  addr;
    logic [15:0] wrData;
  } reg_req_t;

  typedef struct packed {
    logic        voltValid;
    logic [15:0] voltCode;
    logic        currValid;
    logic signed [CURRENT_RAW_W-1:0] currRaw;
  } sample_t;
endpackage

//--- logic/meas_reg_store.sv
// small register store holding the five measurement words
`timescale 1ns/100ps
module meas_reg_store
  import meas_pkg::*;
(
  input  wire logic                clk_sys,
  input  wire logic                rstSync_n,
  input  wire logic [NUM_REGS-1:0] wrSel,
  input  wire logic [15:0]         wrWord [NUM_REGS],
  input  wire logic [2:0]          rdIdx,
  output logic [15:0]              rdData_ff
);
  import meas_pkg::*;
  logic [15:0] word_ff [NUM_REGS];

  // extremes word (index 4) resets to its power-up pattern, others to zero
  genvar gi;
  generate
    for (gi = 0; gi < NUM_REGS; gi++) begin : g_word
      always_ff @(posedge clk_sys or negedge rstSync_n) begin
        if (!rstSync_n) begin
          word_ff[gi] <= (gi == 4) ? EXTREMES_RESET : 16'h0000;
        end else if (wrSel[gi]) begin
          word_ff[gi] <= wrWord[gi];
        end
      end
    end
  endgenerate

  always_ff @(posedge clk_sys or negedge rstSync_n) begin
    if (!rstSync_n) begin
      rdData_ff <= 16'h0000;
    end else if (rdIdx < 3'(NUM_REGS)) begin
      rdData_ff <= word_ff[rdIdx];
    end else begin
      rdData_ff <= 16'h0000;
    end
  end
endmodule

//--- logic/battery_measurement_registers.sv
// battery voltage/current measurement registers with averages and tracker
`timescale 1ns/100ps
module battery_measurement_registers
  import meas_pkg::*;
(
  input  wire logic               clk_sys,
  input  wire logic               rst_n,
  input  wire meas_pkg::reg_req_t regReq,
  input  wire meas_pkg::sample_t  sample,
  output logic                    rdValid,
  output logic [15:0]             rdData
);
  import meas_pkg::*;

  logic        rstMeta_ff;
  logic        rstSync_ff;
  logic        rdPend_ff;
  logic [15:0] volt_ff;
  logic [15:0] curr_ff;
  logic [15:0] voltAvg_ff;
  logic [15:0] currAvg_ff;
  logic [7:0]  extMax_ff;
  logic [7:0]  extMin_ff;
  logic [15:0] nxt_curr;
  logic [15:0] nxt_voltAvg;
  logic [15:0] nxt_currAvg;
  logic [7:0]  voltByte;
  logic        extRestart;
  logic [NUM_REGS-1:0] wrSel;
  logic [15:0] wrWord [NUM_REGS];
  logic [2:0]  rdIdx;
  logic [7:0]  nxt_extMax;
  logic [7:0]  nxt_extMin;
  logic        voltUp;
  logic        voltDown;
  logic signed [16:0] voltDiff;
  logic signed [16:0] currDiff;

  // address to store index; shared by read path
  function automatic logic [2:0] addrIdx(input logic [7:0] a);
    case (a)
      ADDR_BATTERY_VOLTAGE:         addrIdx = 3'h0;
      ADDR_BATTERY_CURRENT:         addrIdx = 3'h1;
      ADDR_BATTERY_CURRENT_AVERAGE: addrIdx = 3'h2;
      ADDR_BATTERY_VOLTAGE_AVERAGE: addrIdx = 3'h3;
      ADDR_VOLTAGE_EXTREMES:        addrIdx = 3'h4;
      default:                      addrIdx = 3'h7;
    endcase
  endfunction

  // 20mV byte is the top byte of the code, truncated rather than rounded
  function automatic logic [7:0] voltToByte(input logic [15:0] code);
    voltToByte = code[15:VOLT_TO_BYTE_SHIFT];
  endfunction

  // clamp the wide raw current to the 16-bit signed code, never wrap
  function automatic logic [15:0] satCurrent(
    input logic signed [CURRENT_RAW_W-1:0] raw);
    logic signed [CURRENT_RAW_W-1:0] hi;
    logic signed [CURRENT_RAW_W-1:0] lo;
    hi = $signed({{(CURRENT_RAW_W-16){1'b0}}, CURRENT_MAX_CODE});
    lo = $signed({{(CURRENT_RAW_W-16){1'b1}}, CURRENT_MIN_CODE});
    if (raw > hi) begin
      satCurrent = CURRENT_MAX_CODE;
    end else if (raw < lo) begin
      satCurrent = CURRENT_MIN_CODE;
    end else begin
      satCurrent = raw[15:0];
    end
  endfunction

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta_ff <= 1'b0;
      rstSync_ff <= 1'b0;
    end else begin
      rstMeta_ff <= 1'b1;
      rstSync_ff <= rstMeta_ff;
    end
  end

  // saturate the wide raw current into the 16-bit signed code
  assign nxt_curr = satCurrent(sample.currRaw);

  // avg += (new - avg) >> k; one extra bit keeps the difference exact
  always_comb begin
    voltDiff    = $signed({1'b0, sample.voltCode}) -
                  $signed({1'b0, voltAvg_ff});
    nxt_voltAvg = voltAvg_ff + 16'(voltDiff >>> AVG_SHIFT);
  end

  // arithmetic shift keeps the current sign; small steps settle to -1
  always_comb begin
    currDiff    = $signed({nxt_curr[15], nxt_curr}) -
                  $signed({currAvg_ff[15], currAvg_ff});
    nxt_currAvg = currAvg_ff + 16'(currDiff >>> AVG_SHIFT);
  end

  assign voltByte   = voltToByte(sample.voltCode);
  assign extRestart = regReq.wrEn &&
                      regReq.addr == ADDR_VOLTAGE_EXTREMES &&
                      regReq.wrData == EXTREMES_RESET;

  always_ff @(posedge clk_sys or negedge rstSync_ff) begin
    if (!rstSync_ff) begin
      volt_ff <= 16'h0000;
    end else if (sample.voltValid) begin
      volt_ff <= sample.voltCode;
    end
  end

  always_ff @(posedge clk_sys or negedge rstSync_ff) begin
    if (!rstSync_ff) begin
      voltAvg_ff <= 16'h0000;
    end else if (sample.voltValid) begin
      voltAvg_ff <= nxt_voltAvg;
    end
  end

  always_ff @(posedge clk_sys or negedge rstSync_ff) begin
    if (!rstSync_ff) begin
      curr_ff <= 16'h0000;
    end else if (sample.currValid) begin
      curr_ff <= nxt_curr;
    end
  end

  always_ff @(posedge clk_sys or negedge rstSync_ff) begin
    if (!rstSync_ff) begin
      currAvg_ff <= 16'h0000;
    end else if (sample.currValid) begin
      currAvg_ff <= nxt_currAvg;
    end
  end

  // restart wins over a coincident sample so software sees a clean start
  always_comb begin
    voltUp     = voltByte > extMax_ff;
    voltDown   = voltByte < extMin_ff;
    nxt_extMax = extMax_ff;
    nxt_extMin = extMin_ff;
    if (extRestart) begin
      nxt_extMax = EXTREME_MAX_RESET;
      nxt_extMin = EXTREME_MIN_RESET;
    end else if (sample.voltValid) begin
      // equal readings leave both bytes alone
      if (voltUp) begin
        nxt_extMax = voltByte;
      end
      if (voltDown) begin
        nxt_extMin = voltByte;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstSync_ff) begin
    if (!rstSync_ff) begin
      extMax_ff <= EXTREME_MAX_RESET;
      extMin_ff <= EXTREME_MIN_RESET;
    end else begin
      extMax_ff <= nxt_extMax;
      extMin_ff <= nxt_extMin;
    end
  end

  // store mirrors live words; host writes reach them only as the extremes restart
  always_comb begin
    wrSel     = {NUM_REGS{1'b1}};
    wrWord[0] = volt_ff;
    wrWord[1] = curr_ff;
    wrWord[2] = currAvg_ff;
    wrWord[3] = voltAvg_ff;
    wrWord[4] = {extMax_ff, extMin_ff};
  end

  assign rdIdx = addrIdx(regReq.addr);

  meas_reg_store u_store (
    .clk_sys   (clk_sys),
    .rstSync_n (rstSync_ff),
    .wrSel     (wrSel),
    .wrWord    (wrWord),
    .rdIdx     (rdIdx),
    .rdData_ff (rdData)
  );

  always_ff @(posedge clk_sys or negedge rstSync_ff) begin
    if (!rstSync_ff) begin
      rdPend_ff <= 1'b0;
    end else begin
      rdPend_ff <= regReq.rdEn;
    end
  end

  assign rdValid = rdPend_ff;
endmodule

//--- testbench/bmr_chk.sv
// checker for the measurement register bank ports
`timescale 1ns/100ps
module bmr_chk
  import meas_pkg::*;
(
  input wire logic               clk_sys,
  input wire logic               rst_n,
  input wire meas_pkg::reg_req_t regReq,
  input wire meas_pkg::sample_t  sample,
  input wire logic               rdValid,
  input wire logic [15:0]        rdData
);
  import meas_pkg::*;
  logic [1:0]  q;
  logic [15:0] v, va, c, ca, mm, cs;
  wire  [7:0]  b  = sample.voltCode[15:8];
  wire  [7:0]  ad = regReq.addr;
  // reads too close to a sample or write see the store lag, skip them
  wire         rq = regReq.rdEn && q == 2'd3;
  always_comb
    if (sample.currRaw > 20'sd32767) cs = CURRENT_MAX_CODE;
    else if (sample.currRaw < -20'sd32768) cs = CURRENT_MIN_CODE;
    else cs = sample.currRaw[15:0];
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n) begin
      {v, va, c, ca} <= '0;
      mm <= EXTREMES_RESET;
      q <= '0;
    end else begin
      q <= (sample.voltValid || sample.currValid || regReq.wrEn) ? 2'd0 :
           (q == 2'd3 ? q : q + 2'd1);
      if (sample.voltValid) begin
        v <= sample.voltCode;
        va <= va + 16'($signed({1'b0, sample.voltCode} - {1'b0, va})
              >>> AVG_SHIFT);
      end
      if (sample.currValid) begin
        c <= cs;
        ca <= ca + 16'(($signed({cs[15], cs}) - $signed({ca[15], ca}))
              >>> AVG_SHIFT);
      end
      if (regReq.wrEn && ad == ADDR_VOLTAGE_EXTREMES &&
          regReq.wrData == EXTREMES_RESET) mm <= EXTREMES_RESET;
      else if (sample.voltValid) begin
        if (b > mm[15:8]) mm[15:8] <= b;
        if (b < mm[7:0]) mm[7:0] <= b;
      end
    end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  a_read_answer:
  assert property (regReq.rdEn |=> rdValid) else $error("read not answered");
  a_valid_pulse:
  assert property (!regReq.rdEn |=> !rdValid) else $error("stray valid");
  a_volt_word:
  assert property (rq && ad == ADDR_BATTERY_VOLTAGE |=> rdData == $past(v))
    else $error("voltage word wrong");
  a_vavg_word:
  assert property (rq && ad == ADDR_BATTERY_VOLTAGE_AVERAGE |=>
    rdData == $past(va)) else $error("voltage average wrong");
  a_extr_word:
  assert property (rq && ad == ADDR_VOLTAGE_EXTREMES |=> rdData == $past(mm))
    else $error("extremes word wrong");
  a_curr_word:
  assert property (rq && ad == ADDR_BATTERY_CURRENT |=> rdData == $past(c))
    else $error("current word wrong");
  a_cavg_word:
  assert property (rq && ad == ADDR_BATTERY_CURRENT_AVERAGE |=>
    rdData == $past(ca)) else $error("current average wrong");
  a_unmapped_zero:
  assert property (rq && ad == 8'h00 |=> rdData == 16'h0000)
    else $error("unmapped read not zero");
endmodule
bind battery_measurement_registers bmr_chk i_chk (.clk_sys(clk_sys),
  .rst_n(rst_n), .regReq(regReq), .sample(sample), .rdValid(rdValid),
  .rdData(rdData));

//--- testbench/host_model.sv
// host side model issuing register reads and writes
`timescale 1ns/100ps
module host_model
  import meas_pkg::*;
(
  input  wire logic         clk_sys,
  output meas_pkg::reg_req_t regReq,
  input  wire logic         rdValid,
  input  wire logic [15:0]  rdData
);
  import meas_pkg::*;
  initial regReq = '0;
  // idle bus shows inverted values so a stale address cannot pass
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [15:0] d, output logic [15:0] q);
    @(negedge clk_sys);
    regReq = '{w, !w, a, d};
    @(negedge clk_sys);
    q = w ? 16'({15'h0000, rdValid}) : rdData;
    regReq = '{1'b0, 1'b0, ~a, ~d};
  endtask
endmodule

//--- testbench/battery_measurement_registers_bench.sv
// self-checking bench for the measurement register bank
`timescale 1ns/100ps
module battery_measurement_registers_bench;
  import meas_pkg::*;
  logic        clk_sys = 1'b0;
  logic        rst_n   = 1'b0;
  sample_t     sample  = '0;
  reg_req_t    regReq;
  logic        rdValid;
  logic [15:0] rdData, got;
  int          errCount = 0;
  int          nTests   = 0;
  always #25 clk_sys = ~clk_sys;
  battery_measurement_registers i_dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .regReq(regReq), .sample(sample), .rdValid(rdValid), .rdData(rdData));
  host_model i_host (.clk_sys(clk_sys), .regReq(regReq),
    .rdValid(rdValid), .rdData(rdData));
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    nTests++;
    if (g !== e) begin
      errCount++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    i_host.xfer(1'b0, a, 16'h0000, got);
    chk(got, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    i_host.xfer(1'b1, a, d, got);
    chk(got, 16'h0000);
    repeat (2) @(negedge clk_sys);
  endtask
  task automatic smp(input logic [15:0] v, input logic signed [19:0] i);
    @(negedge clk_sys);
    sample = '{1'b1, v, 1'b1, i};
    @(negedge clk_sys);
    sample.voltValid = 1'b0;
    sample.currValid = 1'b0;
    repeat (4) @(negedge clk_sys);
  endtask
  task automatic closeOut;
    $display("comparisons %0d mismatches %0d", nTests, errCount);
    if (errCount == 0 && nTests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (12) @(negedge clk_sys);
    rst_n = 1'b1;
    repeat (3) @(negedge clk_sys);
    rd(ADDR_VOLTAGE_EXTREMES, EXTREMES_RESET);
    rd(ADDR_BATTERY_VOLTAGE, 16'h0000);
    rd(8'h00, 16'h0000);
    $display("test reset values done");
    smp(16'h1230, -20'sd256);
    rd(ADDR_BATTERY_VOLTAGE, 16'h1230);
    rd(ADDR_BATTERY_VOLTAGE_AVERAGE, 16'h0123);
    rd(ADDR_VOLTAGE_EXTREMES, 16'h1212);
    rd(ADDR_BATTERY_CURRENT, 16'hff00);
    rd(ADDR_BATTERY_CURRENT_AVERAGE, 16'hfff0);
    $display("test first sample done");
    smp(16'h20ff, 20'sd40000);
    rd(ADDR_BATTERY_CURRENT, CURRENT_MAX_CODE);
    smp(16'h0a00, -20'sd40000);
    rd(ADDR_BATTERY_CURRENT, CURRENT_MIN_CODE);
    rd(ADDR_VOLTAGE_EXTREMES, 16'h200a);
    $display("test tracking and saturation done");
    wr(ADDR_BATTERY_VOLTAGE, 16'h1234);
    rd(ADDR_BATTERY_VOLTAGE, 16'h0a00);
    wr(ADDR_VOLTAGE_EXTREMES, 16'h1234);
    rd(ADDR_VOLTAGE_EXTREMES, 16'h200a);
    wr(ADDR_VOLTAGE_EXTREMES, EXTREMES_RESET);
    rd(ADDR_VOLTAGE_EXTREMES, EXTREMES_RESET);
    smp(16'h3300, 20'sd0);
    rd(ADDR_VOLTAGE_EXTREMES, 16'h3333);
    $display("test host writes done");
    closeOut;
  end
  // whole run needs under a hundred cycles, allow ample margin
  initial begin
    #(50 * 3000);
    errCount++;
    closeOut;
  end
endmodule
